// ===== design/rhap_pkg.sv
// Shared constants and types for the remote host access port.
package rhap_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int IW_W = 2;
  // Control register field positions.
  localparam int FAST_WR_BIT = 5;
  localparam int LATCH_RD_BIT = 4;
  localparam int LATCH_WR_BIT = 3;
  localparam int SS_BIT = 6;
  localparam int MS_HI = 1;
  localparam int MS_LO = 0;
  // Memory select codes.
  localparam logic [1:0] MS_DATA_MEM = 2'h0;
  localparam logic [1:0] MS_INSTR_MEM = 2'h1;
  localparam logic [1:0] MS_PC_LO = 2'h2;
  localparam logic [1:0] MS_PC_HI = 2'h3;
  // Instruction memory selected and buffered modes after reset.
  localparam logic [7:0] CTRL_RESET = 8'h01;
  // The single-step bit is write only and always reads back low.
  localparam logic [7:0] CTRL_READ_MASK = 8'hbf;
  localparam logic [7:0] PC_STEP = 8'h01;
  localparam logic [IW_W-1:0] WCNT_ZERO = 2'h0;
  localparam logic [IW_W-1:0] WCNT_STEP = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PEND_DLY,
    ST_ARB,
    ST_GRANT,
    ST_ACCESS,
    ST_TERM,
    ST_WDONE,
    ST_RECOVER
  } rhap_state_t;
endpackage : rhap_pkg

// ===== design/rhap_remote_host_access_port.sv
// Remote host access port: arbitration, register and instruction memory access sequencing.
`timescale 1ns/100ps

// Functional notes
// - Memory select 01 routes to instruction memory and is the reset selection.
// - Byte tracker starts low and toggles on every instruction memory access.
// - Other targets keep the tracker; writing select 01 forces it low.
// - Reset forces the tracker to the low byte.
// - Instruction read byte driven one T-state after release rises, valid at ack.
// - Wait input stretches ack; control register returns on bus after ack.
// - Bus floats during remote writes; release held at least three T-states.
// - Instruction write strobe pulses only on the high byte write.
// - Program counter increments one T-state after release falls on high byte.
// - Buffered read keeps release until the host read strobe returns high.
// - Latched read ends without waiting for the host read strobe.
// - Processor regains buses one T-state after release falls.
// - Buffered writes drop ack, raise release, drop write timing one later.
// - Slow buffered write terminates on write strobe rising.
// - Fast buffered write terminates at ack rising, release falls one later.
// - Latched write keeps ack and starts after the write strobe trailing edge.
// - Latched write drops write pending, release rises two T-states later.
// - A new access during a pending latched write sees ack held low.
// - Release falls after write timing rises, then write pending rises.
// - Mode bits pick buffered or latched read, latched, slow or fast write.
// - Select 00 data memory, 10 counter low byte, 11 counter high byte.
// - Command select high addresses the control register itself.
module rhap_remote_host_access_port
  import rhap_pkg::*;
#(
  parameter int DW = rhap_pkg::DATA_W
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic access_enable_n,
  input wire logic remote_read_strobe_n,
  input wire logic remote_write_strobe_n,
  input wire logic cmd_sel,
  input wire logic wait_n,
  input wire logic local_bus_req,
  input wire logic [rhap_pkg::IW_W-1:0] instr_wait_states,
  input wire logic [DW-1:0] ad_in,
  input wire logic [2*DW-1:0] instr_rdata,
  output logic [DW-1:0] ad_out,
  output logic ad_oe,
  output logic transfer_ack,
  output logic local_release,
  output logic int_read_n,
  output logic int_write_n,
  output logic write_pending_n,
  output logic instr_write_strobe_n,
  output logic [2*DW-1:0] instr_wdata,
  output logic [rhap_pkg::PC_W-1:0] instr_addr,
  output logic [DW-1:0] remote_interface_control
);
  import rhap_pkg::*;

  rhap_state_t state_r;
  rhap_state_t state_nxt;
  logic [DW-1:0] ctrl_r;
  logic [PC_W-1:0] pc_r;
  logic [DW-1:0] ilat_r;
  logic [2*DW-1:0] iwdata_r;
  logic istrb_n_r;
  logic hi_byte_r;
  logic is_wr_r;
  logic cmd_r;
  logic latch_acc_r;
  logic latch_req_r;
  logic hold_r;
  logic pc_inc_r;
  logic [IW_W-1:0] wcnt_r;
  logic [DW-1:0] ad_r;
  logic ad_oe_r;

  // Mode decode straight from the control register.
  wire [1:0] memory_select = ctrl_r[MS_HI:MS_LO];
  wire latched_read_sel = ctrl_r[LATCH_RD_BIT];
  wire latched_write_sel = ctrl_r[LATCH_WR_BIT];
  wire fast_buffered_write_sel = ctrl_r[FAST_WR_BIT];
  wire slow_wr = !latched_write_sel && !fast_buffered_write_sel;

  wire rd_req = !access_enable_n && !remote_read_strobe_n && !hold_r;
  wire wr_req = !access_enable_n && !remote_write_strobe_n && !hold_r;
  wire req_any = rd_req || wr_req;
  // Latched writes never start on the falling strobe, only on its trailing edge.
  wire start_buf = rd_req || (wr_req && !latched_write_sel);
  wire latch_start = latch_req_r && remote_write_strobe_n;
  wire tgt_instr = !cmd_r && memory_select == MS_INSTR_MEM;
  wire tgt_data = !cmd_r && memory_select == MS_DATA_MEM;
  wire acc_done = state_r == ST_ACCESS && wcnt_r == WCNT_ZERO && wait_n;
  wire slow_mode = slow_wr && !latch_acc_r;
  wire rd_commit = acc_done && !is_wr_r;
  wire wr_commit = is_wr_r && ((acc_done && !slow_mode)
                   || (state_r == ST_TERM && slow_mode && remote_write_strobe_n));
  wire commit = rd_commit || wr_commit;
  wire release_nxt = state_nxt == ST_GRANT || state_nxt == ST_ACCESS
                     || state_nxt == ST_TERM || state_nxt == ST_WDONE;
  wire [DW-1:0] ctrl_view = ctrl_r & CTRL_READ_MASK;
  wire [DW-1:0] instr_byte = hi_byte_r ? instr_rdata[2*DW-1:DW] : instr_rdata[DW-1:0];
  wire [DW-1:0] pc_byte = memory_select[0] ? pc_r[PC_W-1:DW] : pc_r[DW-1:0];
  // The byte is kept through the first termination cycle, so it still stands when the host
  // samples it on the edge that raises ack.
  wire show_byte = (state_nxt == ST_ACCESS || state_r == ST_ACCESS) && !is_wr_r && !cmd_r
                   && memory_select != MS_DATA_MEM;
  wire [DW-1:0] ad_nxt = !show_byte ? ctrl_view
                        : (memory_select == MS_INSTR_MEM ? instr_byte : pc_byte);
  // The bus is let go for every remote write and for data memory reads.
  wire ad_oe_nxt = !(release_nxt && (is_wr_r || tgt_data));
  wire in_term = state_r == ST_TERM || state_r == ST_WDONE || state_r == ST_RECOVER;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (latch_start)
          state_nxt = ST_PEND_DLY;
        else if (start_buf)
          state_nxt = ST_ARB;
      end
      ST_PEND_DLY: state_nxt = ST_ARB;
      ST_ARB:
      begin
        if (!local_bus_req)
          state_nxt = ST_GRANT;
      end
      ST_GRANT: state_nxt = ST_ACCESS;
      ST_ACCESS:
      begin
        if (acc_done)
          state_nxt = ST_TERM;
      end
      ST_TERM:
      begin
        if (!is_wr_r && !latched_read_sel && !remote_read_strobe_n)
          state_nxt = ST_TERM;
        else if (is_wr_r && slow_mode)
          state_nxt = remote_write_strobe_n ? ST_WDONE : ST_TERM;
        else
          state_nxt = ST_RECOVER;
      end
      ST_WDONE: state_nxt = ST_RECOVER;
      ST_RECOVER: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      is_wr_r <= 1'b0;
      cmd_r <= 1'b0;
      latch_acc_r <= 1'b0;
      latch_req_r <= 1'b0;
      hold_r <= 1'b0;
      wcnt_r <= WCNT_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && wr_req && latched_write_sel && !latch_req_r)
      begin
        latch_req_r <= 1'b1;
        cmd_r <= cmd_sel;
      end
      else if (state_r == ST_IDLE && latch_start)
      begin
        latch_req_r <= 1'b0;
        latch_acc_r <= 1'b1;
        is_wr_r <= 1'b1;
      end
      else if (state_r == ST_IDLE && start_buf)
      begin
        cmd_r <= cmd_sel;
        is_wr_r <= !rd_req;
      end
      if (state_r == ST_RECOVER)
        latch_acc_r <= 1'b0;
      // Latched reads finish early, so a still-low strobe must not restart them.
      if (state_r == ST_TERM && !latch_acc_r)
        hold_r <= 1'b1;
      else if (remote_read_strobe_n && remote_write_strobe_n)
        hold_r <= 1'b0;
      if (state_r == ST_GRANT)
        wcnt_r <= tgt_instr ? instr_wait_states : WCNT_ZERO;
      else if (state_r == ST_ACCESS && wcnt_r != WCNT_ZERO)
        wcnt_r <= wcnt_r - WCNT_STEP;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctrl_r <= CTRL_RESET;
    else if (wr_commit && cmd_r)
      ctrl_r <= ad_in;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hi_byte_r <= 1'b0;
    else if (wr_commit && cmd_r && ad_in[MS_HI:MS_LO] == MS_INSTR_MEM)
      hi_byte_r <= 1'b0;
    else if (commit && tgt_instr)
      hi_byte_r <= !hi_byte_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pc_r <= '0;
      ilat_r <= '0;
      iwdata_r <= '0;
      istrb_n_r <= 1'b1;
      pc_inc_r <= 1'b0;
    end
    else
    begin
      istrb_n_r <= !(wr_commit && tgt_instr && hi_byte_r);
      if (wr_commit && tgt_instr && !hi_byte_r)
        ilat_r <= ad_in;
      if (wr_commit && tgt_instr && hi_byte_r)
        iwdata_r <= {ad_in, ilat_r};
      if (commit && tgt_instr && hi_byte_r)
        pc_inc_r <= 1'b1;
      else if (state_r == ST_RECOVER)
        pc_inc_r <= 1'b0;
      if (state_r == ST_RECOVER && pc_inc_r)
        pc_r <= pc_r + PC_W'(PC_STEP);
      else if (wr_commit && !cmd_r && memory_select == MS_PC_LO)
        pc_r[DW-1:0] <= ad_in;
      else if (wr_commit && !cmd_r && memory_select == MS_PC_HI)
        pc_r[PC_W-1:DW] <= ad_in;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ad_r <= CTRL_RESET & CTRL_READ_MASK;
      ad_oe_r <= 1'b1;
    end
    else
    begin
      ad_r <= ad_nxt;
      ad_oe_r <= ad_oe_nxt;
    end
  end

  assign ad_out = ad_r;
  assign ad_oe = ad_oe_r;
  assign local_release = state_r == ST_GRANT || state_r == ST_ACCESS
                         || state_r == ST_TERM || state_r == ST_WDONE;
  // During a pending latched write any new attempt is stalled by ack.
  assign transfer_ack = (state_r == ST_IDLE) ? !start_buf
                        : (latch_acc_r ? !req_any : in_term);
  assign int_read_n = !(state_r == ST_ACCESS && !is_wr_r);
  assign int_write_n = !(is_wr_r && (state_r == ST_ACCESS
                         || (state_r == ST_TERM && slow_mode)));
  assign write_pending_n = !latch_acc_r;
  assign instr_write_strobe_n = istrb_n_r;
  assign instr_wdata = iwdata_r;
  assign instr_addr = pc_r;
  assign remote_interface_control = ctrl_view;

  sequence s_read_done;
    acc_done && !is_wr_r && latched_read_sel;
  endsequence
  sequence s_latch_finish;
    local_release && latch_acc_r ##1 !local_release && !write_pending_n;
  endsequence

  a_tracker_reset: assert property (@(posedge ref_clk) rst |=> !hi_byte_r)
    else $error("tracker not low after reset");
  a_tracker_toggle: assert property (@(posedge ref_clk) disable iff (rst)
    commit && tgt_instr |=> hi_byte_r != $past(hi_byte_r))
    else $error("tracker did not toggle");
  a_tracker_hold: assert property (@(posedge ref_clk) disable iff (rst)
    commit && !tgt_instr && !cmd_r |=> $stable(hi_byte_r))
    else $error("tracker moved on other target");
  a_istrb_high_only: assert property (@(posedge ref_clk) disable iff (rst)
    !instr_write_strobe_n |-> $past(hi_byte_r) && !hi_byte_r)
    else $error("instruction write on low byte");
  a_write_float: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(local_release) && is_wr_r |-> (local_release && !ad_oe)[*3])
    else $error("write release too short or bus driven");
  a_latched_read_end: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_done |=> transfer_ack && local_release ##1 !local_release ##1 state_r == ST_IDLE)
    else $error("latched read termination wrong");
  a_buffered_hold: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_TERM && !is_wr_r && !latched_read_sel && !remote_read_strobe_n
    |=> local_release)
    else $error("buffered read released early");
  a_wp_order: assert property (@(posedge ref_clk) disable iff (rst)
    s_latch_finish |=> write_pending_n)
    else $error("write pending did not rise after release");
  a_latch_stall: assert property (@(posedge ref_clk) disable iff (rst)
    !write_pending_n && !access_enable_n && !hold_r
    && !(remote_read_strobe_n && remote_write_strobe_n) |-> !transfer_ack)
    else $error("host not stalled during pending write");
  a_read_byte_hold: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(int_read_n) |-> $stable(ad_out))
    else $error("read byte gone when ack rose");
  a_ctrl_return: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(int_read_n) |=> ad_out == remote_interface_control)
    else $error("control register not back on bus");
  a_pc_inc: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(local_release) && pc_inc_r |=> pc_r == $past(pc_r) + PC_W'(PC_STEP))
    else $error("program counter not incremented");
endmodule : rhap_remote_host_access_port

// ===== tb/rhap_instruction_memory_model.sv
// Instruction memory model that sits behind the access port.
`timescale 1ns/100ps
module rhap_instr_mem_model (
  input wire logic ref_clk,
  input wire logic instr_write_strobe_n,
  input wire logic [15:0] instr_addr,
  input wire logic [15:0] instr_wdata,
  output logic [15:0] instr_rdata
);
  logic [15:0] mem [logic [15:0]];
  // Unwritten words read as the inverted address, so a stale word never matches by chance.
  always @(instr_addr or instr_write_strobe_n)
    instr_rdata = mem.exists(instr_addr) ? mem[instr_addr] : ~instr_addr;
  always @(posedge ref_clk)
    if (instr_write_strobe_n === 1'b0)
      mem[instr_addr] = instr_wdata;
endmodule : rhap_instr_mem_model

// ===== tb/tb_top.sv
// Self-checking bench for the remote host access port.
`timescale 1ns/100ps
module tb_top;
  import rhap_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic access_enable_n = 1'b1;
  logic remote_read_strobe_n = 1'b1;
  logic remote_write_strobe_n = 1'b1;
  logic cmd_sel = 1'b0;
  logic wait_n = 1'b1;
  logic local_bus_req = 1'b0;
  logic [IW_W-1:0] instr_wait_states = WCNT_ZERO;
  logic [7:0] ad_in = 8'h00;
  logic [15:0] instr_rdata, instr_wdata, instr_addr, base, w0, w1;
  logic [7:0] ad_out, remote_interface_control, last_rd, cur, exp_rd;
  logic ad_oe, transfer_ack, local_release, int_read_n, int_write_n;
  logic write_pending_n, instr_write_strobe_n;
  logic rd_seen = 1'b0;
  logic bg = 1'b0;
  logic stall_rd = 1'b0;
  int failures = 0, compares = 0, nstrb = 0, estrb = 0;
  logic [7:0] expq [$];
  logic [7:0] modes [4] = '{8'h00, 8'h10, 8'h20, 8'h08};

  always #5 ref_clk = ~ref_clk;

  rhap_remote_host_access_port rhap_remote_host_access_port_inst (.ref_clk, .rst,
    .access_enable_n, .remote_read_strobe_n, .remote_write_strobe_n, .cmd_sel, .wait_n,
    .local_bus_req, .instr_wait_states, .ad_in, .instr_rdata, .ad_out, .ad_oe, .transfer_ack,
    .local_release, .int_read_n, .int_write_n, .write_pending_n, .instr_write_strobe_n,
    .instr_wdata, .instr_addr, .remote_interface_control);

  rhap_instr_mem_model rhap_instr_mem_model_inst (.ref_clk, .instr_write_strobe_n, .instr_addr,
    .instr_wdata, .instr_rdata);

  task automatic fail(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
      fail($sformatf("word %h expected %h", g, e));
  endtask : chk_word

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
      fail($sformatf("read byte %h expected %h", g, e));
  endtask : chk_byte

  task automatic complete_run;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // One host access; data and select stay put for the whole access, as external latches would.
  task automatic acc(input logic wr, input logic cmd, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd_sel = cmd;
    ad_in = d;
    access_enable_n = 1'b0;
    if (wr)
      remote_write_strobe_n = 1'b0;
    else
      remote_read_strobe_n = 1'b0;
    if (wr && cur[LATCH_WR_BIT])
    begin
      @(negedge ref_clk);
      chk_word({15'h0, transfer_ack}, 16'h1);
      remote_write_strobe_n = 1'b1;
      if (stall_rd)
      begin
        // A read right behind the latched write must be held off until the write is done.
        remote_read_strobe_n = 1'b0;
        @(negedge ref_clk);
        chk_word({14'h0, write_pending_n, transfer_ack}, 16'h0);
      end
      else
        access_enable_n = 1'b1;
      while (write_pending_n !== 1'b0 && n < 80)
      begin
        @(negedge ref_clk);
        n++;
      end
      chk_word({15'h0, local_release}, 16'h0);
    end
    while (local_release !== 1'b1 && n < 80)
    begin
      @(negedge ref_clk);
      n++;
    end
    while (transfer_ack !== 1'b1 && n < 80)
    begin
      @(negedge ref_clk);
      n++;
    end
    remote_read_strobe_n = 1'b1;
    remote_write_strobe_n = 1'b1;
    access_enable_n = 1'b1;
    while (!(local_release === 1'b0 && write_pending_n === 1'b1 && transfer_ack === 1'b1)
           && n < 80)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
    if (n >= 80)
    begin
      fail("access timed out");
      complete_run;
    end
  endtask : acc

  task automatic wctl(input logic [7:0] v);
    acc(1'b1, 1'b1, v);
    cur = v;
    chk_word({8'h0, remote_interface_control}, {8'h0, v});
  endtask : wctl

  task automatic rd(input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, 1'b0, 8'h00);
  endtask : rd

  task automatic setpc(input logic [7:0] m, input logic [15:0] a);
    wctl(m | {6'h0, MS_PC_LO});
    acc(1'b1, 1'b0, a[7:0]);
    wctl(m | {6'h0, MS_PC_HI});
    acc(1'b1, 1'b0, a[15:8]);
  endtask : setpc

  // Watches reads: the byte held while internal read timing is low is the one handed over.
  always @(negedge ref_clk)
  begin
    if (int_read_n === 1'b0 && ad_oe === 1'b1)
      last_rd = ad_out;
    else if (rd_seen && expq.size() == 0)
      fail("unexpected read");
    else if (rd_seen)
    begin
      // The byte must still stand in the first cycle with ack high.
      exp_rd = expq.pop_front();
      chk_byte(last_rd, exp_rd);
      chk_byte(ad_out, exp_rd);
    end
    rd_seen = (int_read_n === 1'b0 && ad_oe === 1'b1);
    if (instr_write_strobe_n === 1'b0)
      nstrb++;
  end

  always @(negedge ref_clk)
    if (bg)
    begin
      local_bus_req <= ($urandom_range(3) == 0);
      wait_n <= ($urandom_range(3) != 0);
    end

  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk_word({8'h0, remote_interface_control}, {8'h0, CTRL_RESET});
    chk_word(instr_addr, 16'h0000);
    cur = CTRL_RESET;
    void'($urandom(32'hf9e289b5));
    bg = 1'b1;
    foreach (modes[i])
    begin
      instr_wait_states = IW_W'($urandom_range(3));
      base = 16'($urandom());
      w0 = 16'($urandom());
      w1 = 16'($urandom());
      setpc(modes[i], base);
      rd(base[15:8]);
      chk_word(instr_addr, base);
      wctl(modes[i] | 8'h01);
      acc(1'b1, 1'b0, w0[7:0]);
      expq.push_back(cur);
      acc(1'b0, 1'b1, 8'h00);
      acc(1'b1, 1'b0, w0[15:8]);
      estrb++;
      chk_word(instr_addr, base + 16'h1);
      acc(1'b1, 1'b0, 8'h5a);
      wctl(modes[i] | 8'h01);
      acc(1'b1, 1'b0, w1[7:0]);
      acc(1'b1, 1'b0, w1[15:8]);
      estrb++;
      chk_word(16'(nstrb), 16'(estrb));
      setpc(modes[i], base);
      wctl(modes[i] | 8'h01);
      rd(w0[7:0]);
      rd(w0[15:8]);
      rd(w1[7:0]);
      rd(w1[15:8]);
      if (cur[LATCH_WR_BIT])
      begin
        stall_rd = 1'b1;
        expq.push_back(cur);
        acc(1'b1, 1'b1, cur);
        stall_rd = 1'b0;
      end
      chk_word(instr_addr, base + 16'h2);
      chk_word({8'h0, ad_out}, {8'h0, cur});
    end
    repeat (4) @(negedge ref_clk);
    chk_word(16'(expq.size()), 16'h0);
    complete_run;
  end
endmodule : tb_top
